// File: cpu_mode_and_access_guard.sv
// Function
// (RULE_01) Every reset starts in boot mode, hidden from application code.
// (RULE_02) Boot ends in test mode if available, else system mode.
// (RULE_03) Boot may lead to test or restricted super; never back to boot.
// (RULE_04) Delivery fuse makes test mode unreachable forever.
// (RULE_05) Boot mode exists only in the start-up phase.
// (RULE_06) Status word holds super flag and system flag.
// (RULE_07) Top 128 EEPROM bytes are protected rows, removed from application space.
// (RULE_08) A 32-byte area is readable but never writable by applications.
// (RULE_09) A 16-byte area is writable until software write-protects it.
// (RULE_10) A 32-byte area lets each bit go from zero to one once.
// (RULE_11) Option area is reachable only by configuration firmware; the code also grants it to test mode.
// (RULE_12) Disabled card blocks every later application start.
// (RULE_13) Each memory split in two; only test mode reaches both parts.
// (RULE_14) Accesses beyond present or configured memory raise an exception.
// (RULE_15) Full register rights except restricted super mode, using two frozen registers.
// (RULE_16) Refused register writes do nothing; refused reads return a fixed value.
// (RULE_17) Some registers have two copies selected by the current mode.
// (RULE_18) Configuration vector enters restricted super mode; system vector raises exception.
// (RULE_19) Return from interrupt restores the status word saved at the event.
// (RULE_20) Software writes may only clear the super flag.
// (RULE_21) Using a disabled coprocessor raises an exception.
// (RULE_22) Options stay rewritable until locked by firmware, then frozen.
// (RULE_23) Exceptions branch to a source-dependent address in system mode.
// (RULE_24) Rights registers are writable only from system mode.
`timescale 1ns/1ps
`include "guard_consts.svh"
module cpu_mode_and_access_guard
  import guard_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Synchronous reset
  input wire logic testAvail, // Test circuitry present
  input wire logic deliveryFuse, // Delivery fuse blown
  input wire logic lockNv, // Stored option lock
  input wire logic cardDisOpt, // Card disable option fitted
  input wire logic cardDisNv, // Stored card disabled state
  input wire logic wpLockNv, // Stored write-protect state
  input wire logic bootDone, // Boot sequence finished
  input wire logic cvecCall, // Configuration vector call
  input wire logic svecCall, // System vector call
  input wire logic retiExec, // Return from interrupt
  input wire logic pswWrite, // Status word write
  input wire logic pswWrSuper, // Written super flag value
  input wire logic extExc, // Other exception source
  input wire logic cardDisableReq, // Software disables card
  input wire logic wpProtectReq, // Software write-protects area
  input wire logic cfgLockReq, // Firmware locks options
  input wire logic copUse, // Coprocessor access attempt
  input wire logic memReq, // Memory access
  input wire logic memWrite, // Memory write
  input wire logic [1:0] memType, // Memory type
  input wire logic [15:0] memAddr, // Physical address
  input wire logic [7:0] memWrIn, // Write data
  input wire logic [7:0] memOld, // Current stored byte
  input wire logic sfrReq, // Register access
  input wire logic sfrWrite, // Register write
  input wire logic [7:0] sfrAddr, // Register address
  input wire logic [7:0] sfrWrIn, // Register write data
  input wire logic [7:0] sfrRdIn, // Register read data
  input wire logic sfrFuncRd, // Register readable by function
  input wire logic sfrFuncWr, // Register writable by function
  output logic superFlag, // Super system flag
  output logic systemFlag, // System mode flag
  output logic [3:0] modeOut, // Current mode
  output logic appStart, // Application start pulse
  output logic excPulse, // Exception pulse
  output logic [7:0] excVector, // Exception address
  output logic memGrant, // Access granted
  output logic memDenied, // Access refused
  output logic [7:0] memWrOut, // Data to store
  output logic sfrGrant, // Register access granted
  output logic [7:0] sfrRdOut, // Register read result
  output logic sfrBankSuper, // Super copy selected
  output logic optEeFull, // Full EEPROM size option
  output logic optCopEn, // Coprocessor enabled option
  output logic optLocked // Options frozen
);
  localparam guard_state_t RESET_ST = '{mode: MODE_BOOT, savedMode: MODE_BOOT,
    optEeFull: `OPT_EE_RESET, optCopEn: `OPT_COP_RESET, rightsRd: `RIGHTS_RESET,
    rightsWr: `RIGHTS_RESET, superFlag: 1'b1, excVec: `EXC_VEC_MEM,
    sfrRdOut: `SFR_FIXED, bankSuper: 1'b1, default: '0};

  guard_state_t q;
  guard_state_t d;
  guard_if gif ();
  logic halted;
  logic excMem;
  logic excCop;
  logic excAny;
  logic memOk;
  logic sfrOk;
  logic rightsHit;
  logic [7:0] sfrData;

  mem_region_check u_mem (
    .g(gif.mem)
  );

  sfr_rights u_sfr (
    .g(gif.sfr)
  );

  assign gif.mode = q.mode;
  assign gif.memType = memType;
  assign gif.addr = memAddr;
  assign gif.eeLimit = q.optEeFull ? `EE_FULL_END : `EE_REDUCED_END;
  assign gif.sfrAddr = sfrAddr;
  assign gif.funcRd = sfrFuncRd;
  assign gif.funcWr = sfrFuncWr;
  assign gif.rightsRd = q.rightsRd;
  assign gif.rightsWr = q.rightsWr;

  function automatic logic memAllowed(input mode_t m, input region_t r, input logic wr,
    input logic wpl, input logic lk);
    if (m == MODE_TEST) return 1'b1;
    case (r)
      RG_APP: return 1'b1;
      RG_RO: return !wr;
      RG_WP: return !wr || !wpl;
      RG_WO: return 1'b1;
      RG_CFG: return (m == MODE_RSUPER) && !(wr && lk);
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.appStart = 1'b0;
    d.excPulse = 1'b0;
    d.memGrant = 1'b0;
    d.memDenied = 1'b0;
    d.sfrGrant = 1'b0;
    halted = (q.mode == MODE_BOOT) && cardDisOpt && q.cardDead;
    excMem = memReq && gif.outOfRange;
    excCop = copUse && !q.optCopEn;
    excAny = excMem || svecCall || excCop || extExc;
    memOk = memAllowed(q.mode, gif.region, memWrite, q.wpLocked, q.locked);
    rightsHit = (sfrAddr == `SFR_RIGHTS_RD) || (sfrAddr == `SFR_RIGHTS_WR);
    sfrData = sfrRdIn;
    sfrOk = 1'b0;
    if (q.mode == MODE_BOOT)
    begin
      d.testOk = testAvail && !deliveryFuse; //RULE_04
      d.locked = q.locked || lockNv;
      d.cardDead = q.cardDead || cardDisNv;
      d.wpLocked = q.wpLocked || wpLockNv;
    end
    if (halted)
    begin
      // Card disabled: stay in boot, start nothing
      d.mode = MODE_BOOT; //RULE_12
    end
    else if (excAny)
    begin
      d.savedMode = q.mode;
      d.mode = MODE_SYSTEM; //RULE_23
      d.excPulse = 1'b1;
      if (excMem) d.excVec = `EXC_VEC_MEM; //RULE_14
      else if (svecCall) d.excVec = `EXC_VEC_SYSTEM_VECTOR; //RULE_18
      else if (excCop) d.excVec = `EXC_VEC_COP; //RULE_21
      else d.excVec = `EXC_VEC_EXT;
    end
    else if (cvecCall)
    begin
      d.savedMode = q.mode;
      d.mode = MODE_RSUPER; //RULE_18
    end
    else if (retiExec)
    begin
      // Restore, but boot can never come back
      if (q.savedMode != MODE_BOOT) d.mode = q.savedMode; //RULE_19 RULE_03
    end
    else
    begin
      case (q.mode)
        MODE_BOOT:
        begin
          if (bootDone && q.testOk && !deliveryFuse) d.mode = MODE_TEST; //RULE_02
          else if (bootDone)
          begin
            d.mode = MODE_SYSTEM; //RULE_02
            d.appStart = 1'b1;
          end
        end
        MODE_TEST, MODE_RSUPER:
        begin
          // Writes can clear the super flag only
          if (pswWrite && !pswWrSuper) d.mode = MODE_SYSTEM; //RULE_20
        end
        MODE_SYSTEM:
        begin
          d.mode = MODE_SYSTEM; //RULE_20
        end
        default:
        begin
          d.mode = MODE_SYSTEM; //RULE_05
        end
      endcase
    end
    if (cardDisableReq && cardDisOpt && q.mode == MODE_SYSTEM) d.cardDead = 1'b1; //RULE_12
    if (wpProtectReq && q.mode == MODE_SYSTEM) d.wpLocked = 1'b1; //RULE_09
    if (cfgLockReq && q.mode == MODE_RSUPER) d.locked = 1'b1; //RULE_22
    // Memory accesses
    if (memReq && !halted)
    begin
      if (gif.outOfRange)
      begin
        d.memDenied = 1'b1; //RULE_14
      end
      else if (memOk)
      begin
        d.memGrant = 1'b1; //RULE_11
        d.memWrOut = memWrIn;
        if (memWrite && gif.region == RG_WO && q.mode != MODE_TEST)
        begin
          d.memWrOut = memWrIn | memOld; //RULE_10
        end
        if (memWrite && gif.region == RG_CFG && !q.locked)
        begin
          d.optEeFull = memWrIn[`OPT_EE_BIT]; //RULE_22
          d.optCopEn = memWrIn[`OPT_COP_BIT];
        end
      end
      else
      begin
        d.memDenied = 1'b1; //RULE_08
      end
    end
    // Register accesses
    if (sfrReq)
    begin
      if (rightsHit)
      begin
        sfrOk = !sfrWrite || (q.mode == MODE_SYSTEM); //RULE_24
        sfrData = (sfrAddr == `SFR_RIGHTS_RD) ? q.rightsRd : q.rightsWr;
        if (sfrOk && sfrWrite && sfrAddr == `SFR_RIGHTS_RD) d.rightsRd = sfrWrIn; //RULE_15
        if (sfrOk && sfrWrite && sfrAddr == `SFR_RIGHTS_WR) d.rightsWr = sfrWrIn; //RULE_15
      end
      else
      begin
        sfrOk = sfrWrite ? gif.wrAllow : gif.rdAllow; //RULE_16
      end
      d.sfrGrant = sfrOk;
      d.sfrRdOut = (!sfrWrite && sfrOk) ? sfrData : `SFR_FIXED; //RULE_16
    end
    d.superFlag = (d.mode != MODE_SYSTEM); //RULE_06
    d.systemFlag = (d.mode == MODE_SYSTEM); //RULE_06
    d.bankSuper = (d.mode != MODE_SYSTEM); //RULE_17
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn) q <= RESET_ST; //RULE_01
    else q <= d;
  end

  assign superFlag = q.superFlag;
  assign systemFlag = q.systemFlag;
  assign modeOut = q.mode;
  assign appStart = q.appStart;
  assign excPulse = q.excPulse;
  assign excVector = q.excVec;
  assign memGrant = q.memGrant;
  assign memDenied = q.memDenied;
  assign memWrOut = q.memWrOut;
  assign sfrGrant = q.sfrGrant;
  assign sfrRdOut = q.sfrRdOut;
  assign sfrBankSuper = q.bankSuper;
  assign optEeFull = q.optEeFull;
  assign optCopEn = q.optCopEn;
  assign optLocked = q.locked;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  chk_boot_first: assert property ($rose(resetn) |-> q.mode == MODE_BOOT && !appStart) //RULE_01
    else $error("not in boot after reset");
  chk_boot_exit: assert property (q.mode == MODE_BOOT && bootDone && !halted && !excAny //RULE_02
    && !cvecCall && !retiExec |=> q.mode == ($past(q.testOk) ? MODE_TEST : MODE_SYSTEM))
    else $error("wrong mode after boot");
  chk_no_reentry: assert property (q.mode != MODE_BOOT |=> q.mode != MODE_BOOT) //RULE_03
    else $error("boot mode re-entered");
  chk_test_fused: assert property (deliveryFuse && q.mode == MODE_BOOT //RULE_04
    |=> q.mode != MODE_TEST)
    else $error("test mode after delivery");
  chk_flag_pair: assert property (superFlag == !systemFlag //RULE_06
    && superFlag == (q.mode != MODE_SYSTEM))
    else $error("status flags inconsistent");
  chk_ro_write: assert property (memReq && memWrite && !halted && q.mode != MODE_TEST //RULE_08
    && gif.region == RG_RO |=> !memGrant && memDenied)
    else $error("read-only area written");
  chk_wp_locked: assert property (memReq && memWrite && !halted && q.mode != MODE_TEST //RULE_09
    && gif.region == RG_WP && q.wpLocked |=> !memGrant)
    else $error("protected area written");
  chk_wo_merge: assert property (memReq && memWrite && !halted && !gif.outOfRange //RULE_10
    && q.mode != MODE_TEST && gif.region == RG_WO
    |=> memGrant && memWrOut == ($past(memWrIn) | $past(memOld)))
    else $error("write-once bit cleared");
  chk_cfg_app: assert property (memReq && !halted && q.mode == MODE_SYSTEM //RULE_11
    && gif.region == RG_CFG |=> !memGrant)
    else $error("option area reached by application");
  chk_card_block: assert property (halted |=> q.mode == MODE_BOOT && !appStart) //RULE_12
    else $error("disabled card started");
  chk_range_exc: assert property (memReq && gif.outOfRange && !halted //RULE_14
    |=> excPulse && excVector == `EXC_VEC_MEM && !memGrant)
    else $error("out of range not trapped");
  chk_rights_frozen: assert property (q.mode != MODE_SYSTEM //RULE_24
    |=> $stable(q.rightsRd) && $stable(q.rightsWr))
    else $error("rights changed outside system mode");
  chk_denied_fixed: assert property (sfrReq && !sfrWrite && !sfrOk //RULE_16
    |=> sfrRdOut == `SFR_FIXED)
    else $error("refused read not fixed");
  chk_bank_sel: assert property (q.mode == MODE_SYSTEM |-> !sfrBankSuper) //RULE_17
    else $error("wrong register copy");
  chk_configuration_vector_enter: assert property (cvecCall && !excAny && !halted //RULE_18
    |=> q.mode == MODE_RSUPER && superFlag)
    else $error("vector call not entering restricted mode");
  chk_system_vector_exc: assert property (svecCall && !halted //RULE_18
    |=> excPulse && q.mode == MODE_SYSTEM)
    else $error("system vector not trapped");
  chk_reti_back: assert property (retiExec && !excAny && !cvecCall && !halted //RULE_19
    && q.savedMode != MODE_BOOT |=> q.mode == $past(q.savedMode))
    else $error("return did not restore");
  chk_psw_noset: assert property (q.mode == MODE_SYSTEM && !cvecCall && !retiExec //RULE_20
    |=> q.mode == MODE_SYSTEM)
    else $error("super mode entered from system");
  chk_cop_exc: assert property (copUse && !q.optCopEn && !halted |=> excPulse) //RULE_21
    else $error("disabled coprocessor not trapped");
  chk_opt_frozen: assert property (q.locked //RULE_22
    |=> $stable(q.optEeFull) && $stable(q.optCopEn))
    else $error("locked options changed");
  chk_exc_system: assert property (excAny && !halted //RULE_23
    |=> q.mode == MODE_SYSTEM && excPulse)
    else $error("exception not in system mode");

  cov_app_start: cover property (q.mode == MODE_BOOT ##1 appStart);
  cov_rsuper: cover property (q.mode == MODE_SYSTEM ##1 q.mode == MODE_RSUPER);
  cov_wo_write: cover property (memReq && memWrite && gif.region == RG_WO ##1 memGrant);
  cov_exc_reti: cover property (excPulse ##[1:20] retiExec);
endmodule

// File: guard_consts.svh
`ifndef GUARD_CONSTS_SVH
`define GUARD_CONSTS_SVH
// ----------------------------------------
// Mode and region encodings
// ----------------------------------------
`define MODE_BOOT_CODE 4'h1
`define MODE_TEST_CODE 4'h2
`define MODE_RSUPER_CODE 4'h4
`define MODE_SYSTEM_CODE 4'h8
`define RG_APP_CODE 3'h0
`define RG_RO_CODE 3'h1
`define RG_WP_CODE 3'h2
`define RG_WO_CODE 3'h3
`define RG_CFG_CODE 3'h4
`define RG_RSV_CODE 3'h5
// ----------------------------------------
// Memory map
// ----------------------------------------
`define MEMT_ROM 2'h0
`define MEMT_RAM 2'h1
`define MEMT_EE 2'h2
`define ROM_PHYS_END 16'h8000
`define ROM_SPLIT 16'h4000
`define RAM_PHYS_END 16'h0800
`define RAM_SPLIT 16'h0400
`define EE_PHYS_END 16'h4000
`define EE_FULL_END 16'h3000
`define EE_REDUCED_END 16'h2000
`define ROW_SIZE 16'h0080
`define RO_END 16'h0020
`define WP_END 16'h0030
`define WO_END 16'h0050
`define CFG_END 16'h0060
// ----------------------------------------
// Exceptions, registers, reset values
// ----------------------------------------
`define EXC_VEC_MEM 8'h10
`define EXC_VEC_SYSTEM_VECTOR 8'h18
`define EXC_VEC_COP 8'h20
`define EXC_VEC_EXT 8'h28
`define SFR_FIXED 8'h00
`define SFR_RIGHTS_RD 8'hf0
`define SFR_RIGHTS_WR 8'hf1
`define SFR_GRP_MSB 7
`define SFR_GRP_LSB 5
`define OPT_EE_BIT 0
`define OPT_COP_BIT 1
`define OPT_EE_RESET 1'b1
`define OPT_COP_RESET 1'b1
`define RIGHTS_RESET 8'h00
`endif

// File: guard_pkg.sv
`include "guard_consts.svh"
package guard_pkg;
  typedef enum logic [3:0] {
    MODE_BOOT = `MODE_BOOT_CODE,
    MODE_TEST = `MODE_TEST_CODE,
    MODE_RSUPER = `MODE_RSUPER_CODE,
    MODE_SYSTEM = `MODE_SYSTEM_CODE
  } mode_t;
  typedef enum logic [2:0] {
    RG_APP = `RG_APP_CODE,
    RG_RO = `RG_RO_CODE,
    RG_WP = `RG_WP_CODE,
    RG_WO = `RG_WO_CODE,
    RG_CFG = `RG_CFG_CODE,
    RG_RSV = `RG_RSV_CODE
  } region_t;
  typedef struct packed {
    mode_t mode;
    mode_t savedMode;
    logic testOk;
    logic locked;
    logic cardDead;
    logic wpLocked;
    logic optEeFull;
    logic optCopEn;
    logic [7:0] rightsRd;
    logic [7:0] rightsWr;
    logic superFlag;
    logic systemFlag;
    logic bankSuper;
    logic appStart;
    logic excPulse;
    logic [7:0] excVec;
    logic memGrant;
    logic memDenied;
    logic [7:0] memWrOut;
    logic sfrGrant;
    logic [7:0] sfrRdOut;
  } guard_state_t;
endpackage

// File: guard_if.sv
`timescale 1ns/1ps
interface guard_if;
  import guard_pkg::*;
  mode_t mode;
  logic [1:0] memType;
  logic [15:0] addr;
  logic [15:0] eeLimit;
  region_t region;
  logic outOfRange;
  logic [7:0] sfrAddr;
  logic funcRd;
  logic funcWr;
  logic [7:0] rightsRd;
  logic [7:0] rightsWr;
  logic rdAllow;
  logic wrAllow;
  modport main (output mode, memType, addr, eeLimit, sfrAddr, funcRd, funcWr, rightsRd,
    rightsWr, input region, outOfRange, rdAllow, wrAllow);
  modport mem (input mode, memType, addr, eeLimit, output region, outOfRange);
  modport sfr (input mode, sfrAddr, funcRd, funcWr, rightsRd, rightsWr,
    output rdAllow, wrAllow);
endinterface

// File: mem_region_check.sv
`timescale 1ns/1ps
`include "guard_consts.svh"
module mem_region_check
  import guard_pkg::*;
(
  guard_if.mem g // Address classification
);
  logic [15:0] limit;
  logic [15:0] rowBase;
  logic [15:0] off;

  function automatic region_t regionOf(input logic [15:0] o);
    if (o < `RO_END) return RG_RO;
    else if (o < `WP_END) return RG_WP;
    else if (o < `WO_END) return RG_WO;
    else if (o < `CFG_END) return RG_CFG;
    else return RG_RSV;
  endfunction

  always_comb
  begin
    rowBase = g.eeLimit - `ROW_SIZE;
    off = g.addr - rowBase;
    // Test mode sees both parts, others only the lower part
    if (g.memType == `MEMT_ROM) limit = (g.mode == MODE_TEST) ? `ROM_PHYS_END
      : `ROM_SPLIT; //RULE_13
    else if (g.memType == `MEMT_RAM) limit = (g.mode == MODE_TEST) ? `RAM_PHYS_END : `RAM_SPLIT;
    else if (g.memType == `MEMT_EE) limit = (g.mode == MODE_TEST) ? `EE_PHYS_END : g.eeLimit;
    else limit = 16'h0000;
    g.outOfRange = (g.addr >= limit); //RULE_14
    g.region = RG_APP;
    if (g.memType == `MEMT_EE && g.addr >= rowBase && g.addr < g.eeLimit)
    begin
      g.region = regionOf(off); //RULE_07
    end
  end
endmodule

// File: sfr_rights.sv
`timescale 1ns/1ps
`include "guard_consts.svh"
module sfr_rights
  import guard_pkg::*;
(
  guard_if.sfr g // Register access rights
);
  logic [2:0] grp;
  logic rsuper;

  function automatic logic gate(input logic func, input logic right, input logic rs);
    return func && (!rs || right);
  endfunction

  always_comb
  begin
    grp = g.sfrAddr[`SFR_GRP_MSB:`SFR_GRP_LSB];
    rsuper = (g.mode == MODE_RSUPER);
    // Full rights except in restricted super mode
    g.rdAllow = gate(g.funcRd, g.rightsRd[grp], rsuper); //RULE_15
    g.wrAllow = gate(g.funcWr, g.rightsWr[grp], rsuper); //RULE_15
  end
endmodule

// File: mem_store_model.sv
`timescale 1ns/1ps
module mem_store_model (
  input wire logic clk_sys, // System clock
  input wire logic memReq, // Access request
  input wire logic memWrite, // Write request
  input wire logic [15:0] memAddr, // Physical address
  input wire logic memGrant, // Access granted
  input wire logic [7:0] memWrOut, // Data to store
  output logic [7:0] memOld // Stored byte at address
);
  logic [7:0] cells [256];
  logic [7:0] pendAddr;
  logic pendWr;
  // ----------------------------------------
  // Byte store seen by the guard
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 256; i++)
      cells[i] = 8'h00;
    cells[8'hb0] = 8'h80;
    pendWr = 1'b0;
    pendAddr = 8'h00;
  end
  always @(posedge clk_sys)
  begin
    if (memGrant && pendWr)
      cells[pendAddr] <= memWrOut;
    if (memReq)
    begin
      pendAddr <= memAddr[7:0];
      pendWr <= memWrite;
    end
  end
  // Forward the byte still being written to a back-to-back access
  assign memOld = (memGrant && pendWr && pendAddr == memAddr[7:0]) ? memWrOut
    : cells[memAddr[7:0]];
endmodule

// File: tb_cpu_mode_and_access_guard.sv
`timescale 1ns/1ps
module tb_cpu_mode_and_access_guard;
  import guard_pkg::*;
  logic clk_sys, resetn, testAvail, deliveryFuse, lockNv, cardDisOpt, cardDisNv, wpLockNv;
  logic bootDone, cvecCall, svecCall, retiExec, pswWrite, pswWrSuper, extExc;
  logic cardDisableReq, wpProtectReq, cfgLockReq, copUse, memReq, memWrite;
  logic [1:0] memType;
  logic [15:0] memAddr;
  logic [7:0] memWrIn, memOld, sfrAddr, sfrWrIn, sfrRdIn, excVector, memWrOut, sfrRdOut;
  logic sfrReq, sfrWrite, sfrFuncRd, sfrFuncWr, superFlag, systemFlag, appStart, excPulse;
  logic memGrant, memDenied, sfrGrant, sfrBankSuper, optEeFull, optCopEn, optLocked;
  logic [3:0] modeOut;
  int errors = 0;
  int totalChecks = 0;
  cpu_mode_and_access_guard uut (.clk_sys, .resetn, .testAvail, .deliveryFuse, .lockNv,
    .cardDisOpt, .cardDisNv, .wpLockNv, .bootDone, .cvecCall, .svecCall, .retiExec,
    .pswWrite, .pswWrSuper, .extExc, .cardDisableReq, .wpProtectReq, .cfgLockReq, .copUse,
    .memReq, .memWrite, .memType, .memAddr, .memWrIn, .memOld, .sfrReq, .sfrWrite, .sfrAddr,
    .sfrWrIn, .sfrRdIn, .sfrFuncRd, .sfrFuncWr, .superFlag, .systemFlag, .modeOut, .appStart,
    .excPulse, .excVector, .memGrant, .memDenied, .memWrOut, .sfrGrant, .sfrRdOut,
    .sfrBankSuper, .optEeFull, .optCopEn, .optLocked);
  mem_store_model store (.clk_sys, .memReq, .memWrite, .memAddr, .memGrant, .memWrOut,
    .memOld);
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
    totalChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic checkMode(input logic [3:0] exp, input string what);
    checkByte({3'h0, superFlag, exp === 4'h8 ? systemFlag : ~systemFlag, 3'h0},
      {3'h0, exp !== 4'h8, 1'b1, 3'h0}, what);
    checkByte({4'h0, modeOut}, {4'h0, exp}, what);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic doReset(input logic ta, input logic fuse, input logic cdOpt, input logic cdNv);
    resetn = 1'b0;
    testAvail = ta;
    deliveryFuse = fuse;
    cardDisOpt = cdOpt;
    cardDisNv = cdNv;
    step(12);
    resetn = 1'b1;
    step(2);
    checkMode(4'h1, "boot after reset");
    pulse(bootDone);
  endtask
  task automatic memOp(input logic wr, input logic [1:0] t, input logic [15:0] a,
    input logic [7:0] d, input logic [1:0] expGd);
    step(1);
    memWrite = wr;
    memType = t;
    memAddr = a;
    memWrIn = d;
    pulse(memReq);
    checkByte({6'h0, memGrant, memDenied}, {6'h0, expGd}, "memory answer");
  endtask
  task automatic sfrOp(input logic wr, input logic [7:0] a, input logic [7:0] d,
    input logic expG, input logic [7:0] expRd);
    step(1);
    sfrWrite = wr;
    sfrAddr = a;
    sfrWrIn = d;
    pulse(sfrReq);
    checkByte({7'h0, sfrGrant}, {7'h0, expG}, "register grant");
    checkByte(sfrRdOut, expRd, "register read data");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testBootSystem();
    doReset(1'b0, 1'b0, 1'b0, 1'b0);
    checkMode(4'h8, "boot to system");
    checkByte({7'h0, appStart}, 8'h01, "application start");
    pswWrSuper = 1'b1;
    pulse(pswWrite);
    checkByte({7'h0, appStart}, 8'h00, "start pulse width");
    checkMode(4'h8, "super flag set refused");
    pulse(bootDone);
    checkMode(4'h8, "no return to boot");
    $display("test boot_system done");
  endtask
  task automatic testVectors();
    pulse(cvecCall);
    checkMode(4'h4, "configuration vector");
    checkByte({7'h0, sfrBankSuper}, 8'h01, "super copy");
    pulse(retiExec);
    checkMode(4'h8, "return restores");
    checkByte({7'h0, sfrBankSuper}, 8'h00, "system copy");
    pulse(svecCall);
    checkByte({excPulse, excVector[6:0]}, 8'h98, "system vector trap");
    pulse(cvecCall);
    pulse(extExc);
    checkByte({excPulse, excVector[6:0]}, 8'ha8, "other exception");
    checkMode(4'h8, "exception to system");
    $display("test vectors done");
  endtask
  task automatic testMemory();
    memOp(1'b1, 2'h2, 16'h2f80, 8'h11, 2'h1);
    memOp(1'b0, 2'h2, 16'h2f80, 8'h00, 2'h2);
    memOp(1'b1, 2'h2, 16'h2fb0, 8'h01, 2'h2);
    checkByte(memWrOut, 8'h81, "write once sets bit");
    memOp(1'b1, 2'h2, 16'h2fb0, 8'h00, 2'h2);
    checkByte(memWrOut, 8'h81, "write once keeps bits");
    memOp(1'b1, 2'h2, 16'h2fa0, 8'h33, 2'h2);
    pulse(wpProtectReq);
    memOp(1'b1, 2'h2, 16'h2fa0, 8'h44, 2'h1);
    memOp(1'b0, 2'h2, 16'h2fd0, 8'h00, 2'h1);
    memOp(1'b0, 2'h1, 16'h0400, 8'h00, 2'h1);
    memOp(1'b0, 2'h2, 16'h3000, 8'h00, 2'h1);
    checkByte({excPulse, excVector[6:0]}, 8'h90, "range exception");
    $display("test memory done");
  endtask
  task automatic testSfr();
    sfrOp(1'b0, 8'hf0, 8'h00, 1'b1, 8'h00);
    pulse(cvecCall);
    sfrOp(1'b0, 8'h40, 8'h00, 1'b0, 8'h00);
    sfrOp(1'b1, 8'hf0, 8'h04, 1'b0, 8'h00);
    pulse(retiExec);
    sfrOp(1'b0, 8'hf0, 8'h00, 1'b1, 8'h00);
    sfrOp(1'b1, 8'hf0, 8'h04, 1'b1, 8'h00);
    pulse(cvecCall);
    sfrOp(1'b0, 8'h40, 8'h00, 1'b1, 8'h5a);
    pulse(retiExec);
    $display("test registers done");
  endtask
  task automatic testOptions();
    pulse(cvecCall);
    memOp(1'b1, 2'h2, 16'h2fd0, 8'h01, 2'h2);
    checkByte({6'h0, optEeFull, optCopEn}, 8'h02, "options loaded");
    pulse(cfgLockReq);
    checkByte({7'h0, optLocked}, 8'h01, "options locked");
    memOp(1'b1, 2'h2, 16'h2fd0, 8'h03, 2'h1);
    checkByte({6'h0, optEeFull, optCopEn}, 8'h02, "options frozen");
    pulse(retiExec);
    pulse(copUse);
    checkByte({excPulse, excVector[6:0]}, 8'ha0, "coprocessor trap");
    $display("test options done");
  endtask
  task automatic testStartModes();
    {lockNv, wpLockNv} = 2'h3;
    doReset(1'b1, 1'b1, 1'b0, 1'b0);
    checkMode(4'h8, "fused part skips test");
    memOp(1'b1, 2'h2, 16'h2fa0, 8'h55, 2'h1);
    pulse(cvecCall);
    memOp(1'b1, 2'h2, 16'h2fd0, 8'h01, 2'h1);
    doReset(1'b1, 1'b0, 1'b0, 1'b0);
    checkMode(4'h2, "test mode entered");
    pswWrSuper = 1'b0;
    pulse(pswWrite);
    checkMode(4'h8, "super flag cleared");
    doReset(1'b0, 1'b0, 1'b1, 1'b1);
    checkMode(4'h1, "disabled card held");
    checkByte({7'h0, appStart}, 8'h00, "no application start");
    pulse(cardDisableReq);
    $display("test start_modes done");
  endtask
  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {resetn, testAvail, deliveryFuse, lockNv, cardDisOpt, cardDisNv, wpLockNv} = 7'h00;
    {bootDone, cvecCall, svecCall, retiExec, pswWrite, pswWrSuper, extExc} = 7'h00;
    {cardDisableReq, wpProtectReq, cfgLockReq, copUse, memReq, memWrite} = 6'h00;
    {sfrReq, sfrWrite, memType, memAddr, memWrIn, sfrAddr, sfrWrIn} = 44'h0;
    sfrRdIn = 8'h5a;
    sfrFuncRd = 1'b1;
    sfrFuncWr = 1'b1;
    testBootSystem();
    testVectors();
    testMemory();
    testSfr();
    testOptions();
    testStartModes();
    tally_and_finish();
  end
endmodule
